// ---- src/isp_pkg.sv ----
// Shared constants and types of the two-wire slave register port.
// Assumes a single system clock domain; the link pins are asynchronous to it.
package isp_pkg;

  // ----------------------------------------------------------------
  // Slave addresses per strap connection
  // ----------------------------------------------------------------
  localparam logic [6:0] ISP_ADDR_STRAP_SUPPLY = 7'h4c;
  localparam logic [6:0] ISP_ADDR_STRAP_GROUND = 7'h4d;
  localparam logic [6:0] ISP_ADDR_STRAP_DATA = 7'h4e;
  localparam logic [6:0] ISP_ADDR_STRAP_CLOCK = 7'h4f;

  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam logic [3:0] ISP_LAST_DATA_BIT = 4'h7;
  localparam logic [3:0] ISP_ACK_BIT = 4'h8;
  localparam int ISP_DIR_BIT_POS = 0;
  localparam logic ISP_DIR_READ = 1'b1;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] ISP_PTR_RESET = 8'h00;
  localparam logic [7:0] ISP_BYTE_RESET = 8'h00;
  localparam logic ISP_PIN_IDLE = 1'b1;

  // ----------------------------------------------------------------
  // Frame states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ISP_ST_IDLE,
    ISP_ST_ADDR,
    ISP_ST_CMD,
    ISP_ST_WDATA,
    ISP_ST_RDATA,
    ISP_ST_IGNORE
  } isp_state_t;

endpackage

// ---- src/isp_link_sync.sv ----
// Pin synchroniser and bus event detector for the two-wire link.
// Assumes clock, data and strap pins are asynchronous to sys_clk.
`timescale 1ns/10ps
module isp_link_sync
  import isp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic scl_pin,
  input wire logic sda_pin,
  input wire logic strap_pin,
  output logic scl,
  output logic sda,
  output logic strap,
  output logic scl_rise,
  output logic scl_fall,
  output logic start_det,
  output logic stop_det
);

  logic scl_meta;
  logic sda_meta;
  logic strap_meta;
  logic scl_prev;
  logic sda_prev;

  // ----------------------------------------------------------------
  // Two-stage synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      scl_meta <= ISP_PIN_IDLE;
      sda_meta <= ISP_PIN_IDLE;
      strap_meta <= ISP_PIN_IDLE;
      scl <= ISP_PIN_IDLE;
      sda <= ISP_PIN_IDLE;
      strap <= ISP_PIN_IDLE;
    end
    else
    begin
      scl_meta <= scl_pin;
      sda_meta <= sda_pin;
      strap_meta <= strap_pin;
      scl <= scl_meta;
      sda <= sda_meta;
      strap <= strap_meta;
    end
  end

  // ----------------------------------------------------------------
  // Edge and condition detection
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      scl_prev <= ISP_PIN_IDLE;
      sda_prev <= ISP_PIN_IDLE;
      scl_rise <= 1'b0;
      scl_fall <= 1'b0;
      start_det <= 1'b0;
      stop_det <= 1'b0;
    end
    else
    begin
      scl_prev <= scl;
      sda_prev <= sda;
      scl_rise <= scl & ~scl_prev;
      scl_fall <= ~scl & scl_prev;
      // Data edges while the clock stays high
      start_det <= scl & scl_prev & sda_prev & ~sda;
      stop_det <= scl & scl_prev & ~sda_prev & sda;
    end
  end

endmodule

// ---- src/isp_addr_strap.sv ----
// Slave address selection from the strap pin connection.
// Assumes synchronised strap, clock and data levels from the pin synchroniser.
`timescale 1ns/10ps
module isp_addr_strap
  import isp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic strap,
  input wire logic scl,
  input wire logic sda,
  output logic [6:0] own_addr
);

  logic seen_low;
  logic differs_sda;
  logic differs_scl;

  // ----------------------------------------------------------------
  // Strap observation
  // ----------------------------------------------------------------
  // The strap is classified by watching which line it follows; a START
  // always pulls the data line low before the address byte completes.
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      seen_low <= 1'b0;
      differs_sda <= 1'b0;
      differs_scl <= 1'b0;
    end
    else
    begin
      seen_low <= seen_low | ~strap;
      differs_sda <= differs_sda | (strap ^ sda);
      differs_scl <= differs_scl | (strap ^ scl);
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      own_addr <= ISP_ADDR_STRAP_SUPPLY;
    end
    else if (!seen_low)
    begin
      own_addr <= ISP_ADDR_STRAP_SUPPLY;
    end
    else if (!differs_sda)
    begin
      own_addr <= ISP_ADDR_STRAP_DATA;
    end
    else if (!differs_scl)
    begin
      own_addr <= ISP_ADDR_STRAP_CLOCK;
    end
    else
    begin
      own_addr <= ISP_ADDR_STRAP_GROUND;
    end
  end

endmodule

// ---- src/isp_slave_port.sv ----
// Two-wire slave port giving a bus master access to the register file
// through an auto-incrementing register pointer.
// Assumes a register file on sys_clk that answers reg_rdata for reg_addr
// combinationally and takes reg_wdata on a reg_wr_en pulse.
`timescale 1ns/10ps
module isp_slave_port
  import isp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic scl_pin,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic strap_pin,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr_en,
  output logic reg_rd_en,
  input wire logic [7:0] reg_rdata,
  output logic busy
);

  logic scl;
  logic sda;
  logic strap;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic [6:0] own_addr;
  isp_state_t state;
  isp_state_t next_state;
  logic [3:0] bit_cnt;
  logic [7:0] rx_byte;
  logic [7:0] tx_byte;
  logic [7:0] ptr;
  logic master_ack;
  logic byte_done;
  logic ack_end;
  logic addr_hit;
  logic load_read;
  logic start_fall;

  function automatic logic [7:0] isp_next_ptr(input logic [7:0] cur);
    isp_next_ptr = cur + 8'h01;
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisation and strap decode
  // ----------------------------------------------------------------
  isp_link_sync i_isp_link_sync (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .scl_pin(scl_pin),
    .sda_pin(sda_in),
    .strap_pin(strap_pin),
    .scl(scl),
    .sda(sda),
    .strap(strap),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .start_det(start_det),
    .stop_det(stop_det)
  );

  isp_addr_strap i_isp_addr_strap (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .strap(strap),
    .scl(scl),
    .sda(sda),
    .own_addr(own_addr)
  );

  // ----------------------------------------------------------------
  // Frame decode
  // ----------------------------------------------------------------
  assign byte_done = scl_fall && (bit_cnt == ISP_LAST_DATA_BIT);
  assign ack_end = scl_fall && (bit_cnt == ISP_ACK_BIT);
  assign addr_hit = (rx_byte[7:1] == own_addr);

  // Sends the next read byte at the end of an acknowledge slot
  assign load_read = ((state == ISP_ST_ADDR) && addr_hit
                      && (rx_byte[ISP_DIR_BIT_POS] == ISP_DIR_READ))
                     || ((state == ISP_ST_RDATA) && master_ack);

  always_comb
  begin
    next_state = state;
    unique case (state)
      ISP_ST_IDLE:
        next_state = ISP_ST_IDLE;
      ISP_ST_ADDR:
      begin
        if (!addr_hit)
        begin
          next_state = ISP_ST_IGNORE;
        end
        else if (rx_byte[ISP_DIR_BIT_POS] == ISP_DIR_READ)
        begin
          next_state = ISP_ST_RDATA;
        end
        else
        begin
          next_state = ISP_ST_CMD;
        end
      end
      ISP_ST_CMD:
        next_state = ISP_ST_WDATA;
      ISP_ST_WDATA:
        next_state = ISP_ST_WDATA;
      ISP_ST_RDATA:
        next_state = master_ack ? ISP_ST_RDATA : ISP_ST_IGNORE;
      ISP_ST_IGNORE:
        next_state = ISP_ST_IGNORE;
    endcase
  end

  // ----------------------------------------------------------------
  // State and bit counter
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state <= ISP_ST_IDLE;
      bit_cnt <= 4'h0;
      start_fall <= 1'b0;
    end
    else if (start_det)
    begin
      // A repeated start re-arms address matching at once
      state <= ISP_ST_ADDR;
      bit_cnt <= 4'h0;
      start_fall <= 1'b1;
    end
    else if (stop_det)
    begin
      state <= ISP_ST_IDLE;
      bit_cnt <= 4'h0;
      start_fall <= 1'b0;
    end
    else if (scl_fall && start_fall)
    begin
      // The clock fall that closes a start condition carries no bit
      start_fall <= 1'b0;
    end
    else if (scl_fall && (state != ISP_ST_IDLE) && (state != ISP_ST_IGNORE))
    begin
      if (bit_cnt == ISP_ACK_BIT)
      begin
        bit_cnt <= 4'h0;
        state <= next_state;
      end
      else
      begin
        bit_cnt <= bit_cnt + 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Bit sampling on clock rise
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rx_byte <= ISP_BYTE_RESET;
      master_ack <= 1'b0;
    end
    else if (scl_rise)
    begin
      if (bit_cnt <= ISP_LAST_DATA_BIT)
      begin
        rx_byte <= {rx_byte[6:0], sda};
      end
      else if (state == ISP_ST_RDATA)
      begin
        master_ack <= ~sda;
      end
    end
  end

  // ----------------------------------------------------------------
  // Data line driver
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sda_oe <= 1'b0;
      sda_out <= 1'b0;
      tx_byte <= ISP_BYTE_RESET;
    end
    else if (start_det || stop_det)
    begin
      sda_oe <= 1'b0;
    end
    else if (byte_done)
    begin
      unique case (state)
        ISP_ST_ADDR:
          sda_oe <= addr_hit;
        ISP_ST_CMD, ISP_ST_WDATA:
          sda_oe <= 1'b1;
        default:
          sda_oe <= 1'b0;
      endcase
    end
    else if (ack_end)
    begin
      if (load_read)
      begin
        tx_byte <= reg_rdata;
        sda_oe <= ~reg_rdata[7];
      end
      else
      begin
        sda_oe <= 1'b0;
      end
    end
    else if (scl_fall && (state == ISP_ST_RDATA) && (bit_cnt < ISP_LAST_DATA_BIT))
    begin
      tx_byte <= {tx_byte[6:0], 1'b0};
      sda_oe <= ~tx_byte[6];
    end
  end

  // ----------------------------------------------------------------
  // Register pointer
  // ----------------------------------------------------------------
  // A stop after the command byte leaves the new pointer and nothing else.
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ptr <= ISP_PTR_RESET;
    end
    else if (ack_end && (state == ISP_ST_CMD))
    begin
      ptr <= rx_byte;
    end
    else if (ack_end && (state == ISP_ST_WDATA))
    begin
      ptr <= isp_next_ptr(ptr);
    end
    else if (byte_done && (state == ISP_ST_RDATA))
    begin
      ptr <= isp_next_ptr(ptr);
    end
  end

  assign reg_addr = ptr;

  // ----------------------------------------------------------------
  // Register file strobes
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      reg_wr_en <= 1'b0;
      reg_rd_en <= 1'b0;
      reg_wdata <= ISP_BYTE_RESET;
    end
    else
    begin
      reg_wr_en <= byte_done && (state == ISP_ST_WDATA);
      reg_rd_en <= ack_end && load_read;
      if (byte_done && (state == ISP_ST_WDATA))
      begin
        reg_wdata <= rx_byte;
      end
    end
  end

  // ----------------------------------------------------------------
  // Engagement status
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      busy <= 1'b0;
    end
    else
    begin
      busy <= (state != ISP_ST_IDLE) && (state != ISP_ST_IGNORE)
              && (state != ISP_ST_ADDR);
    end
  end

endmodule

// ---- bench/isp_slave_port_assertions.sv ----
// Concurrent checks on the top ports of the two-wire slave register port.
// Assumes a link bit of about 8 sys_clk cycles, as the bench master makes it.
`timescale 1ns/10ps
module isp_slave_port_assertions (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic scl_pin,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic busy
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  logic scl_q;
  logic [3:0] since_fall;
  logic [7:0] wr_ptr;
  logic [7:0] rd_ptr;

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      scl_q <= 1'b1;
      since_fall <= 4'hf;
    end
    else
    begin
      scl_q <= scl_pin;
      if (scl_q && !scl_pin)
        since_fall <= 4'h0;
      else if (since_fall != 4'hf)
        since_fall <= since_fall + 4'h1;
    end
  end

  // Pointer seen at each strobe
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wr_ptr <= 8'h00;
      rd_ptr <= 8'h00;
    end
    else
    begin
      if (reg_wr_en)
        wr_ptr <= reg_addr;
      if (reg_rd_en)
        rd_ptr <= reg_addr;
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  sequence s_stop_seen;
    scl_pin && $rose(sda_in);
  endsequence

  a_pull_low_only: assert property (sda_oe |-> !sda_out)
    else $error("data driven high");
  a_drive_after_fall: assert property ($rose(sda_oe) |-> since_fall >= 4'h1 && since_fall <= 4'h6)
    else $error("data drive not tied to clock fall");
  a_stop_frees: assert property (s_stop_seen |-> ##[1:8] (!busy && !sda_oe))
    else $error("stop did not free the port");
  a_wr_single: assert property (reg_wr_en |=> !reg_wr_en && !reg_rd_en)
    else $error("write strobe too long");
  a_wr_engaged: assert property (reg_wr_en |-> busy)
    else $error("write while not engaged");
  a_wdata_hold: assert property (reg_wr_en |=> $stable(reg_wdata) [*8])
    else $error("write data not held");
  a_wr_ptr_step: assert property (reg_wr_en |-> ##[4:12] (reg_addr == wr_ptr + 8'h01))
    else $error("pointer not advanced after write");
  a_rd_ptr_step: assert property (reg_rd_en |-> ##[40:80] (reg_addr == rd_ptr + 8'h01))
    else $error("pointer not advanced after read");
  a_rd_single: assert property (reg_rd_en |=> (busy && !reg_rd_en))
    else $error("read strobe wrong");
endmodule

// ---- bench/isp_mst.sv ----
// Behavioural bus master: makes the link clock and drives the data wire.
// Assumes the bench resolves the wire with a pull-up; one bit takes 400 ns.
`timescale 1ns/10ps
module isp_mst (
  output logic scl,
  output logic sda_drv,
  input wire logic sda
);
  initial
  begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  // Data moves only with the clock low; long low phase leaves the slave time
  task automatic bit_io(input logic b, output logic r);
    sda_drv = b;
    #250;
    scl = 1'b1;
    #50;
    r = sda;
    #50;
    scl = 1'b0;
    #50;
  endtask

  task automatic start();
    sda_drv = 1'b1;
    #250;
    scl = 1'b1;
    #100;
    sda_drv = 1'b0;
    #100;
    scl = 1'b0;
    #50;
  endtask

  task automatic stop();
    sda_drv = 1'b0;
    #250;
    scl = 1'b1;
    #100;
    sda_drv = 1'b1;
    #200;
  endtask

  task automatic wr(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(b[i], r);
    bit_io(1'b1, ack);
  endtask

  task automatic rd(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(nack, r);
  endtask
endmodule

// ---- bench/isp_slave_port_tb.sv ----
// Self-checking bench of the two-wire slave register port.
// Assumes the master model isp_mst and the bound checker.
`timescale 1ns/10ps
module isp_slave_port_tb
  import isp_pkg::*;
;
  logic sys_clk, resetn, sda_w, strap_w, scl_m, sda_m, sda_out, sda_oe;
  logic reg_wr_en, reg_rd_en, busy;
  logic [1:0] strap_sel;
  logic [7:0] reg_addr, reg_wdata;
  logic [7:0] regs [256];
  int errors;
  int tests_run;

  assign sda_w = sda_m & ~(sda_oe & ~sda_out);
  assign strap_w = (strap_sel == 2'h0) ? 1'b1 : (strap_sel == 2'h1) ? 1'b0 :
                   (strap_sel == 2'h2) ? sda_w : scl_m;

  isp_mst i_isp_mst (.scl(scl_m), .sda_drv(sda_m), .sda(sda_w));
  isp_slave_port i_isp_slave_port (.sys_clk(sys_clk), .resetn(resetn), .scl_pin(scl_m),
    .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe), .strap_pin(strap_w),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_rdata(regs[reg_addr]), .busy(busy));

  initial sys_clk = 1'b0;
  always #25 sys_clk = ~sys_clk;

  // Register file beside the port
  always @(posedge sys_clk)
  begin
    if (reg_wr_en === 1'b1)
      regs[reg_addr] <= reg_wdata;
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic do_reset(input logic [1:0] sel);
    @(posedge sys_clk);
    #5;
    resetn = 1'b0;
    strap_sel = sel;
    repeat (6) @(posedge sys_clk);
    #5;
    resetn = 1'b1;
    repeat (4) @(posedge sys_clk);
    #5;
  endtask

  task automatic t_strap();
    logic [6:0] own;
    logic [6:0] addr;
    logic ack;
    for (int s = 0; s < 4; s++)
    begin
      do_reset(2'(s));
      own = (s == 0) ? ISP_ADDR_STRAP_SUPPLY : (s == 1) ? ISP_ADDR_STRAP_GROUND :
            (s == 2) ? ISP_ADDR_STRAP_DATA : ISP_ADDR_STRAP_CLOCK;
      for (int a = 0; a < 4; a++)
      begin
        addr = ISP_ADDR_STRAP_SUPPLY + 7'(a);
        i_isp_mst.start();
        i_isp_mst.wr({addr, 1'b0}, ack);
        chk("addr ack", {7'h00, addr != own}, {7'h00, ack});
        i_isp_mst.wr(8'h00, ack);
        chk("next ack", {7'h00, addr != own}, {7'h00, ack});
        i_isp_mst.stop();
      end
    end
  endtask

  task automatic t_write();
    logic ack;
    do_reset(2'h0);
    i_isp_mst.start();
    i_isp_mst.wr({ISP_ADDR_STRAP_SUPPLY, 1'b0}, ack);
    i_isp_mst.wr(8'hfe, ack);
    chk("cmd ack", 8'h00, {7'h00, ack});
    for (int i = 0; i < 3; i++)
    begin
      i_isp_mst.wr(8'ha0 + 8'(i), ack);
      chk("data ack", 8'h00, {7'h00, ack});
    end
    i_isp_mst.stop();
    chk("reg fe", 8'ha0, regs[8'hfe]);
    chk("reg ff", 8'ha1, regs[8'hff]);
    chk("reg 00", 8'ha2, regs[8'h00]);
  endtask

  task automatic t_read();
    logic ack;
    logic [7:0] d;
    regs[8'h40] = 8'h11;
    regs[8'h41] = 8'h22;
    regs[8'h42] = 8'h33;
    i_isp_mst.start();
    i_isp_mst.wr({ISP_ADDR_STRAP_SUPPLY, 1'b0}, ack);
    i_isp_mst.wr(8'h40, ack);
    i_isp_mst.stop();
    chk("pointer", 8'h40, reg_addr);
    chk("reg 40", 8'h11, regs[8'h40]);
    i_isp_mst.start();
    i_isp_mst.wr({ISP_ADDR_STRAP_SUPPLY, 1'b0}, ack);
    i_isp_mst.wr(8'h41, ack);
    i_isp_mst.start();
    i_isp_mst.wr({ISP_ADDR_STRAP_SUPPLY, ISP_DIR_READ}, ack);
    chk("read ack", 8'h00, {7'h00, ack});
    for (int i = 0; i < 2; i++)
    begin
      i_isp_mst.rd(i == 1, d);
      chk("read data", 8'h22 + 8'h11 * 8'(i), d);
    end
    repeat (5) @(posedge sys_clk);
    #5;
    chk("released", 8'h00, {7'h00, sda_oe});
    i_isp_mst.stop();
  endtask

  // Disturbed write cut by a start, then the pointer is written again
  task automatic t_rewrite();
    logic ack;
    logic r;
    i_isp_mst.start();
    i_isp_mst.wr({ISP_ADDR_STRAP_SUPPLY, 1'b0}, ack);
    i_isp_mst.wr(8'h10, ack);
    for (int i = 0; i < 4; i++)
      i_isp_mst.bit_io(1'b1, r);
    i_isp_mst.start();
    i_isp_mst.wr({ISP_ADDR_STRAP_SUPPLY, 1'b0}, ack);
    i_isp_mst.wr(8'h5e, ack);
    i_isp_mst.wr(8'h0c, ack);
    chk("config ack", 8'h00, {7'h00, ack});
    i_isp_mst.stop();
    chk("reg 10", 8'h00, regs[8'h10]);
    chk("reg 5e", 8'h0c, regs[8'h5e]);
  endtask

  task automatic print_verdict();
    $display("tests_run=%0d errors=%0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    errors = 0;
    tests_run = 0;
    resetn = 1'b0;
    strap_sel = 2'h0;
    for (int i = 0; i < 256; i++)
      regs[i] = 8'h00;
    t_strap();
    t_write();
    t_read();
    t_rewrite();
    print_verdict();
  end

  // Watchdog: run needs about 0.2 ms
  initial
  begin
    #2000000;
    errors++;
    print_verdict();
  end
endmodule

bind isp_slave_port isp_slave_port_assertions i_isp_slave_port_assertions (
  .sys_clk(sys_clk), .resetn(resetn), .scl_pin(scl_pin), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .busy(busy));
